// [common/t3rsc_pkg.sv]
// Constants, field positions and clock-source codes for the reload/split/capture timer.
// Assumes the register port is a byte-wide special function register bus.
package t3rsc_pkg;
	// Register addresses
	localparam logic [7:0] ADDR_CTL = 8'h91;
	localparam logic [7:0] ADDR_RLL = 8'h92;
	localparam logic [7:0] ADDR_RLH = 8'h93;
	localparam logic [7:0] ADDR_CNTL = 8'h94;
	localparam logic [7:0] ADDR_CNTH = 8'h95;
	// Control register field positions
	localparam int BIT_HOF = 7;
	localparam int BIT_LOF = 6;
	localparam int BIT_LIE = 5;
	localparam int BIT_CAP = 4;
	localparam int BIT_SPLIT = 3;
	localparam int BIT_RUN = 2;
	localparam int BIT_RCLK = 1;
	localparam int BIT_XCLK = 0;
	// Values after reset, and the largest byte value
	localparam logic [7:0] RST_CTL = 8'h00;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [7:0] BYTE_MAX = 8'hff;
	// Prescaler counts
	localparam int SYS_DIV = 12;
	localparam int EXT_DIV = 8;
	localparam logic [3:0] DIV12_LAST = 4'(SYS_DIV - 1);
	// Counting clock sources
	typedef enum logic [1:0] {
		SRC_SYS = 2'b00,
		SRC_DIV12 = 2'b01,
		SRC_EXT = 2'b10,
		SRC_RTC = 2'b11
	} t3rsc_src_e;
endpackage

// [design/t3rsc_tick_div.sv]
// Synchroniser and divide-by-N tick for a slow free-running clock input.
// Assumes clk_in runs at less than half of clk_sys.
`timescale 1ns/10ps
`default_nettype none
module t3rsc_tick_div #(
	parameter int DIV = t3rsc_pkg::EXT_DIV
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Slow clock in, one-cycle tick out
	input wire logic clk_in,
	output logic tick
);
	localparam int W = $clog2(DIV);
	localparam logic [W-1:0] LAST = W'(DIV - 1);
	typedef struct packed {
		logic sync1;
		logic sync2;
		logic prev;
		logic [W-1:0] div;
		logic tick;
	} t3rsc_div_s;
	t3rsc_div_s st_ff;
	t3rsc_div_s nxt_st;
	logic edge_seen;

	// Two flops bring the slow clock in; only sync2 onward feeds logic
	always_comb begin
		nxt_st = st_ff;
		nxt_st.sync1 = clk_in;
		nxt_st.sync2 = st_ff.sync1;
		nxt_st.prev = st_ff.sync2;
		edge_seen = st_ff.sync2 & ~st_ff.prev;
		nxt_st.tick = 1'b0;
		if (edge_seen) begin
			// Every DIV rising edges give one tick
			nxt_st.tick = (st_ff.div == LAST);
			nxt_st.div = (st_ff.div == LAST) ? '0 : st_ff.div + 1'b1;
		end
	end

	// State register
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign tick = st_ff.tick;

	// A tick is a single-cycle pulse that only follows a synchronised edge
	property p_tick_pulse;
		@(posedge clk_sys) disable iff (reset) st_ff.tick |-> $past(edge_seen) ##1 !st_ff.tick;
	endproperty
	a_tick_pulse: assert property (p_tick_pulse) else $error("tick not a single pulse after an edge");
endmodule
`default_nettype wire

// [design/t3rsc_top.sv]
// Reload/split/capture 16-bit timer with its byte-wide register port.
// Assumes register accesses are synchronous to clk_sys and that the oscillator
// inputs are slower than half of clk_sys.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - 16-bit mode counts up; on wrap reloads from both reload bytes and sets high flag; capture mode wraps to zero without the high flag.
// - 16-bit mode: interrupt requested on every full overflow outside capture mode when interrupts enabled.
// - 16-bit mode: low byte wrap also interrupts when low enable set.
// - Split mode: two 8-bit counters, each reloading from its own reload byte.
// - Split mode: run bit gates only the high byte; low byte always counts.
// - Each byte clock: fast bit gives system clock, else divide-12 or external/8, or real-time/8 for the low byte in capture mode with capture source set.
// - External divided tick is synchronised to the system clock before use.
// - Split mode: high byte wrap sets high flag, low byte wrap sets low flag.
// - Split mode: high wrap interrupts; with low enable either byte interrupts.
// - Flags are cleared only by software, which checks both flags for the source.
// - Capture event every eight cycles of the oscillator picked by capture source.
// - Capture copies the 16-bit count into the reload bytes and sets high flag.
// - Capture counter clock: system, divide-12, external/8 or real-time/8.
// - Fast low set, capture source clear: count each system clock, capture real-time/8.
module t3rsc_top (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Register port
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_rd,
	output logic [7:0] sfr_rdata,
	// Clock select and interrupt enable from the system
	input wire logic high_byte_fast_clock_sel,
	input wire logic low_byte_fast_clock_sel,
	input wire logic timer_irq_enable,
	// Oscillator inputs
	input wire logic ext_osc_clk,
	input wire logic rtc_clk,
	// Interrupt request
	output logic timer_irq_req
);
	typedef struct packed {
		logic [7:0] ctl;
		logic [7:0] rl_lo;
		logic [7:0] rl_hi;
		logic [7:0] cnt_lo;
		logic [7:0] cnt_hi;
		logic [3:0] div12;
		logic [7:0] rdata;
	} t3rsc_state_s;
	t3rsc_state_s st_ff;
	t3rsc_state_s nxt_st;
	logic ext_tick;
	logic rtc_tick;
	logic div12_tick;
	logic split;
	logic run;
	logic cap_mode;
	logic tick_lo;
	logic tick_hi;
	logic cap_ev;
	logic hset;
	logic lset;
	logic wr_ctl;
	logic wr_cnt;
	logic [15:0] cnt16;
	logic [15:0] rl16;
	logic [7:0] ctl_w;
	t3rsc_pkg::t3rsc_src_e src_lo;
	t3rsc_pkg::t3rsc_src_e src_hi;

	// Source choice per byte; in capture mode the external choice may be the real-time clock
	function automatic t3rsc_pkg::t3rsc_src_e pick_src(input logic fast, input logic xclk, input logic use_rtc);
		if (fast) begin
			pick_src = t3rsc_pkg::SRC_SYS;
		end else if (!xclk) begin
			pick_src = t3rsc_pkg::SRC_DIV12;
		end else if (use_rtc) begin
			pick_src = t3rsc_pkg::SRC_RTC;
		end else begin
			pick_src = t3rsc_pkg::SRC_EXT;
		end
	endfunction

	function automatic logic src_tick(input t3rsc_pkg::t3rsc_src_e s, input logic d12, input logic ext, input logic rtc);
		case (s)
			t3rsc_pkg::SRC_SYS: src_tick = 1'b1;
			t3rsc_pkg::SRC_DIV12: src_tick = d12;
			t3rsc_pkg::SRC_EXT: src_tick = ext;
			default: src_tick = rtc;
		endcase
	endfunction

	// Oscillator ticks, each synchronised and divided by eight
	t3rsc_tick_div #(.DIV(t3rsc_pkg::EXT_DIV)) u_ext_div (
		.clk_sys(clk_sys),
		.reset(reset),
		.clk_in(ext_osc_clk),
		.tick(ext_tick)
	);
	t3rsc_tick_div #(.DIV(t3rsc_pkg::EXT_DIV)) u_rtc_div (
		.clk_sys(clk_sys),
		.reset(reset),
		.clk_in(rtc_clk),
		.tick(rtc_tick)
	);

	// Decoded control bits and selected counting ticks
	assign split = st_ff.ctl[t3rsc_pkg::BIT_SPLIT];
	assign run = st_ff.ctl[t3rsc_pkg::BIT_RUN];
	assign cap_mode = st_ff.ctl[t3rsc_pkg::BIT_CAP] & ~split; // Capture needs the 16-bit layout
	assign div12_tick = (st_ff.div12 == t3rsc_pkg::DIV12_LAST);
	assign src_lo = pick_src(low_byte_fast_clock_sel, st_ff.ctl[t3rsc_pkg::BIT_XCLK],
		cap_mode & st_ff.ctl[t3rsc_pkg::BIT_RCLK]);
	assign src_hi = pick_src(high_byte_fast_clock_sel, st_ff.ctl[t3rsc_pkg::BIT_XCLK], 1'b0);
	assign tick_lo = src_tick(src_lo, div12_tick, ext_tick, rtc_tick);
	assign tick_hi = src_tick(src_hi, div12_tick, ext_tick, rtc_tick);
	// Capture source 0 samples the real-time clock, 1 the external oscillator
	assign cap_ev = cap_mode & (st_ff.ctl[t3rsc_pkg::BIT_RCLK] ? ext_tick : rtc_tick);
	assign cnt16 = {st_ff.cnt_hi, st_ff.cnt_lo};
	assign rl16 = {st_ff.rl_hi, st_ff.rl_lo};
	assign wr_ctl = sfr_wr & (sfr_addr == t3rsc_pkg::ADDR_CTL);
	assign wr_cnt = sfr_wr & ((sfr_addr == t3rsc_pkg::ADDR_CNTL) | (sfr_addr == t3rsc_pkg::ADDR_CNTH));

	// Next state: prescaler, counting, capture, register writes and read data
	always_comb begin
		nxt_st = st_ff;
		hset = 1'b0;
		lset = 1'b0;
		ctl_w = st_ff.ctl;
		nxt_st.div12 = div12_tick ? 4'h0 : st_ff.div12 + 4'h1;
		if (!split) begin
			if (run && tick_lo) begin
				if (cnt16 == 16'hffff) begin
					// In capture mode the reload bytes hold captures, so wrap to zero instead
					{nxt_st.cnt_hi, nxt_st.cnt_lo} = cap_mode ? 16'h0000 : rl16;
					hset = ~cap_mode;
					lset = 1'b1;
				end else begin
					{nxt_st.cnt_hi, nxt_st.cnt_lo} = cnt16 + 16'h0001;
					lset = (st_ff.cnt_lo == t3rsc_pkg::BYTE_MAX);
				end
			end
		end else begin
			if (tick_lo) begin
				// Low byte free-runs in split mode
				nxt_st.cnt_lo = (st_ff.cnt_lo == t3rsc_pkg::BYTE_MAX) ? st_ff.rl_lo : st_ff.cnt_lo + 8'h01;
				lset = (st_ff.cnt_lo == t3rsc_pkg::BYTE_MAX);
			end
			if (run && tick_hi) begin
				nxt_st.cnt_hi = (st_ff.cnt_hi == t3rsc_pkg::BYTE_MAX) ? st_ff.rl_hi : st_ff.cnt_hi + 8'h01;
				hset = (st_ff.cnt_hi == t3rsc_pkg::BYTE_MAX);
			end
		end
		// Software writes win over counting
		if (sfr_wr) begin
			case (sfr_addr)
				t3rsc_pkg::ADDR_CTL: ctl_w = sfr_wdata;
				t3rsc_pkg::ADDR_RLL: nxt_st.rl_lo = sfr_wdata;
				t3rsc_pkg::ADDR_RLH: nxt_st.rl_hi = sfr_wdata;
				t3rsc_pkg::ADDR_CNTL: nxt_st.cnt_lo = sfr_wdata;
				t3rsc_pkg::ADDR_CNTH: nxt_st.cnt_hi = sfr_wdata;
				default: ;
			endcase
		end
		// A capture beats a reload write in the same cycle so no sample is lost
		if (cap_ev) begin
			nxt_st.rl_hi = st_ff.cnt_hi;
			nxt_st.rl_lo = st_ff.cnt_lo;
			hset = 1'b1;
		end
		// Hardware set wins over a software clear; nothing here clears a flag
		ctl_w[t3rsc_pkg::BIT_HOF] = ctl_w[t3rsc_pkg::BIT_HOF] | hset;
		ctl_w[t3rsc_pkg::BIT_LOF] = ctl_w[t3rsc_pkg::BIT_LOF] | lset;
		nxt_st.ctl = ctl_w;
		// Read data is registered; unmapped addresses read zero
		if (sfr_rd) begin
			case (sfr_addr)
				t3rsc_pkg::ADDR_CTL: nxt_st.rdata = st_ff.ctl;
				t3rsc_pkg::ADDR_RLL: nxt_st.rdata = st_ff.rl_lo;
				t3rsc_pkg::ADDR_RLH: nxt_st.rdata = st_ff.rl_hi;
				t3rsc_pkg::ADDR_CNTL: nxt_st.rdata = st_ff.cnt_lo;
				t3rsc_pkg::ADDR_CNTH: nxt_st.rdata = st_ff.cnt_hi;
				default: nxt_st.rdata = 8'h00;
			endcase
		end
	end

	// State register
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			st_ff <= '{ctl: t3rsc_pkg::RST_CTL, rl_lo: t3rsc_pkg::RST_BYTE, rl_hi: t3rsc_pkg::RST_BYTE,
				cnt_lo: t3rsc_pkg::RST_BYTE, cnt_hi: t3rsc_pkg::RST_BYTE, div12: 4'h0, rdata: 8'h00};
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Interrupt request follows the flags and enables, same in both modes
	assign timer_irq_req = timer_irq_enable & (st_ff.ctl[t3rsc_pkg::BIT_HOF] |
		(st_ff.ctl[t3rsc_pkg::BIT_LIE] & st_ff.ctl[t3rsc_pkg::BIT_LOF]));
	assign sfr_rdata = st_ff.rdata;

	// Full overflow reloads the count and raises the high flag on the next edge
	property p_reload16;
		@(posedge clk_sys) disable iff (reset)
		(!split && run && tick_lo && !cap_mode && cnt16 == 16'hffff && !sfr_wr && !cap_ev)
		|=> (cnt16 == $past(rl16)) && st_ff.ctl[t3rsc_pkg::BIT_HOF];
	endproperty
	a_reload16: assert property (p_reload16) else $error("16-bit overflow did not reload and flag");

	property p_irq16;
		@(posedge clk_sys) disable iff (reset)
		(!split && run && tick_lo && !cap_mode && cnt16 == 16'hffff && timer_irq_enable) |=> timer_irq_req;
	endproperty
	a_irq16: assert property (p_irq16) else $error("16-bit overflow gave no interrupt");

	property p_irq_low;
		@(posedge clk_sys) disable iff (reset)
		(!split && run && tick_lo && st_ff.cnt_lo == 8'hff && timer_irq_enable && st_ff.ctl[t3rsc_pkg::BIT_LIE] && !wr_ctl)
		|=> timer_irq_req && st_ff.ctl[t3rsc_pkg::BIT_LOF];
	endproperty
	a_irq_low: assert property (p_irq_low) else $error("low byte wrap gave no interrupt");

	property p_split_lo;
		@(posedge clk_sys) disable iff (reset)
		(split && tick_lo && !wr_cnt) |=>
		st_ff.cnt_lo == (($past(st_ff.cnt_lo) == 8'hff) ? $past(st_ff.rl_lo) : $past(st_ff.cnt_lo) + 8'h01);
	endproperty
	a_split_lo: assert property (p_split_lo) else $error("split low byte miscounted");

	property p_split_hold;
		@(posedge clk_sys) disable iff (reset)
		(split && !run && !wr_cnt) |=> $stable(st_ff.cnt_hi);
	endproperty
	a_split_hold: assert property (p_split_hold) else $error("stopped high byte moved");

	property p_split_hflag;
		@(posedge clk_sys) disable iff (reset)
		(split && run && tick_hi && st_ff.cnt_hi == 8'hff) |=> st_ff.ctl[t3rsc_pkg::BIT_HOF] ##1 1'b1;
	endproperty
	a_split_hflag: assert property (p_split_hflag) else $error("high byte wrap did not flag");

	property p_flag_sticky;
		@(posedge clk_sys) disable iff (reset)
		(st_ff.ctl[t3rsc_pkg::BIT_HOF] && !wr_ctl) |=> st_ff.ctl[t3rsc_pkg::BIT_HOF];
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("high flag cleared by hardware");

	property p_capture;
		@(posedge clk_sys) disable iff (reset)
		cap_ev |=> (rl16 == $past(cnt16)) && st_ff.ctl[t3rsc_pkg::BIT_HOF];
	endproperty
	a_capture: assert property (p_capture) else $error("capture did not copy count");

	property p_fast_lo;
		@(posedge clk_sys) disable iff (reset)
		low_byte_fast_clock_sel |-> tick_lo;
	endproperty
	a_fast_lo: assert property (p_fast_lo) else $error("fast low select did not count every cycle");
endmodule
`default_nettype wire

// [tb/t3rsc_top_test.sv]
// Self-checking bench for the reload/split/capture timer, driven through its register port.
// Assumes the package and design files are compiled first; oscillators run free.
`timescale 1ns/10ps
`default_nettype none
module t3rsc_top_test;
	logic clk_sys, reset, sfr_wr, sfr_rd, hi_fast, lo_fast, irq_en, ext_osc_clk, rtc_clk, irq;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, v;
	logic [15:0] c1, c2;
	int fail_count, n_compared;
	// Device under test
	t3rsc_top u_t3rsc_top (.clk_sys(clk_sys), .reset(reset), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
		.sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .high_byte_fast_clock_sel(hi_fast),
		.low_byte_fast_clock_sel(lo_fast), .timer_irq_enable(irq_en), .ext_osc_clk(ext_osc_clk),
		.rtc_clk(rtc_clk), .timer_irq_req(irq));
	// System clock 25 MHz; oscillators are slow and unrelated in phase
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	initial begin
		ext_osc_clk = 1'b0;
		#7 forever #100 ext_osc_clk = ~ext_osc_clk;
	end
	initial begin
		rtc_clk = 1'b0;
		#13 forever #500 rtc_clk = ~rtc_clk;
	end
	// Compare and count
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// One-cycle strobes, released on the same edge that takes them
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		sfr_wr <= 1'b1;
		sfr_addr <= a;
		sfr_wdata <= d;
		@(posedge clk_sys);
		sfr_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		sfr_rd <= 1'b1;
		sfr_addr <= a;
		@(posedge clk_sys);
		sfr_rd <= 1'b0;
		#1 d = sfr_rdata;
	endtask
	// Poll control until all bits of m are set; a hang counts as a mismatch
	task automatic wait_ctl(input logic [7:0] m, input int lim);
		for (int i = 0; i < lim; i++) begin
			rd(t3rsc_pkg::ADDR_CTL, v);
			if ((v & m) === m) return;
		end
		fail_count++;
		give_verdict();
	endtask
	// Take one capture: wait for the flag, clear it, read the captured count
	task automatic capture(input logic [7:0] c, output logic [15:0] q);
		wait_ctl(8'h80, 400);
		wr(t3rsc_pkg::ADDR_CTL, c);
		rd(t3rsc_pkg::ADDR_RLL, q[7:0]);
		rd(t3rsc_pkg::ADDR_RLH, q[15:8]);
	endtask
	task automatic load(input logic [7:0] cl, input logic [7:0] ch, input logic [7:0] rl, input logic [7:0] rh);
		wr(t3rsc_pkg::ADDR_CTL, 8'h00);
		wr(t3rsc_pkg::ADDR_CNTL, cl);
		wr(t3rsc_pkg::ADDR_CNTH, ch);
		wr(t3rsc_pkg::ADDR_RLL, rl);
		wr(t3rsc_pkg::ADDR_RLH, rh);
	endtask
	// Main sequence
	initial begin
		fail_count = 0;
		n_compared = 0;
		reset = 1'b1;
		{sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = '0;
		{hi_fast, lo_fast, irq_en} = 3'b111;
		repeat (8) @(posedge clk_sys);
		reset <= 1'b0;
		// Reset values, and an unmapped place that ignores writes
		for (int a = 8'h91; a <= 8'h95; a++) begin
			rd(8'(a), v);
			check(v, 8'h00);
		end
		wr(8'h96, 8'h5a);
		rd(8'h96, v);
		check(v, 8'h00);
		// 16-bit wrap reloads both bytes and sets both flags; flags stay set
		load(8'hfe, 8'hff, 8'h10, 8'h20);
		wr(t3rsc_pkg::ADDR_CTL, 8'h04);
		wait_ctl(8'hc0, 20);
		rd(t3rsc_pkg::ADDR_CNTH, v);
		check(v, 8'h20);
		check(8'(irq), 8'h01);
		repeat (20) @(posedge clk_sys);
		rd(t3rsc_pkg::ADDR_CTL, v);
		check(v, 8'hc4);
		wr(t3rsc_pkg::ADDR_CTL, 8'h00);
		rd(t3rsc_pkg::ADDR_CTL, v);
		check(8'(irq), 8'h00);
		// Low byte wrap in 16-bit mode: flag always, interrupt only with the low enable
		load(8'hfe, 8'h00, 8'h00, 8'h00);
		wr(t3rsc_pkg::ADDR_CTL, 8'h04);
		repeat (10) @(posedge clk_sys);
		rd(t3rsc_pkg::ADDR_CTL, v);
		check(v, 8'h44);
		check(8'(irq), 8'h00);
		rd(t3rsc_pkg::ADDR_CNTH, v);
		check(v, 8'h01);
		// Flags cleared, low enable on: the next real wrap of the low byte must interrupt
		wr(t3rsc_pkg::ADDR_CTL, 8'h24);
		wait_ctl(8'h40, 200);
		check(8'(irq), 8'h01);
		// Split mode, run off: low byte counts and reloads, high byte holds
		load(8'hfe, 8'h50, 8'h80, 8'h90);
		wr(t3rsc_pkg::ADDR_CTL, 8'h08);
		repeat (10) @(posedge clk_sys);
		rd(t3rsc_pkg::ADDR_CTL, v);
		check(v, 8'h48);
		check(8'(irq), 8'h00);
		rd(t3rsc_pkg::ADDR_CNTH, v);
		check(v, 8'h50);
		rd(t3rsc_pkg::ADDR_CNTL, v);
		check(v & 8'hf0, 8'h80);
		// Split mode, run on: high byte wraps to its own reload and interrupts
		wr(t3rsc_pkg::ADDR_CNTH, 8'hfe);
		wr(t3rsc_pkg::ADDR_CTL, 8'h0c);
		repeat (6) @(posedge clk_sys);
		rd(t3rsc_pkg::ADDR_CTL, v);
		check(v & 8'h80, 8'h80);
		check(8'(irq), 8'h01);
		rd(t3rsc_pkg::ADDR_CNTH, v);
		check(v & 8'hf0, 8'h90);
		wr(t3rsc_pkg::ADDR_CTL, 8'h68);
		rd(t3rsc_pkg::ADDR_CTL, v);
		check(8'(irq), 8'h01);
		@(posedge clk_sys);
		irq_en <= 1'b0;
		rd(t3rsc_pkg::ADDR_CTL, v);
		check(8'(irq), 8'h00);
		// Slow counting clocks: system /12, external /8 in 16-bit and split mode, real-time /8 in capture mode
		@(posedge clk_sys);
		irq_en <= 1'b1;
		lo_fast <= 1'b0;
		hi_fast <= 1'b0;
		for (int k = 0; k < 4; k++) begin
			load(8'h00, 8'h00, 8'h00, 8'h00);
			wr(t3rsc_pkg::ADDR_CTL, (k < 2) ? 8'(4 + k) : ((k == 2) ? 8'h0d : 8'h17));
			repeat (k ? 400 : 240) @(posedge clk_sys);
			wr(t3rsc_pkg::ADDR_CTL, 8'h00);
			rd(t3rsc_pkg::ADDR_CNTL, v);
			check(8'((v >= 8'd19) && (v <= 8'd21) || k != 0), 8'h01);
			check(8'((v >= 8'd9) && (v <= 8'd11) || k == 0 || k == 3), 8'h01);
			check(8'((v >= 8'd1) && (v <= 8'd3) || k != 3), 8'h01);
			rd(t3rsc_pkg::ADDR_CNTH, v);
			check(8'((k == 2) ? (v >= 8'd9 && v <= 8'd11) : (v == 8'h00)), 8'h01);
		end
		// Capture on real-time /8 then external /8, counting every system clock
		@(posedge clk_sys);
		lo_fast <= 1'b1;
		for (int k = 0; k < 2; k++) begin
			load(8'h00, 8'h00, 8'h00, 8'h00);
			wr(t3rsc_pkg::ADDR_CTL, 8'(8'h14 + 2 * k));
			capture(8'(8'h14 + 2 * k), c1);
			capture(8'(8'h14 + 2 * k), c2);
			c2 = c2 - c1 - (k ? 16'd40 : 16'd200);
			check(8'((c2 + 16'd1) <= 16'd2), 8'h01);
		end
		give_verdict();
	end
	// Hang guard
	initial begin
		repeat (60000) @(posedge clk_sys);
		fail_count++;
		give_verdict();
	end
endmodule
`default_nettype wire
